// ===== core/flpt_top.sv
`timescale 1ns/1ps
`include "flpt_consts.svh"

module flpt_top
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  POWER_GOOD_I,
  input  wire logic                  FEAT_VIRT_I,
  input  wire logic                  FEAT_SAFER_I,
  input  wire logic                  GUEST_XFER_I,
  input  wire logic                  REQ_VALID_I,
  input  wire logic                  REQ_WRITE_I,
  input  wire logic [ADDR_W-1:0]     REQ_ADDR_I,
  input  wire flpt_pkg::flpt_word_type REQ_WDATA_I,
  output logic                       RSP_VALID_O,
  output flpt_pkg::flpt_rsp_type     RSP_KIND_O,
  output flpt_pkg::flpt_word_type    RSP_RDATA_O,
  output logic [31:0]                RSP_ERR_CODE_O,
  output logic                       LOCKED_O,
  output logic                       VIRT_SAFER_EN_O,
  output logic                       VIRT_PLAIN_EN_O,
  output flpt_pkg::flpt_local_type   LAUNCH_LOCAL_EN_O,
  output logic                       LAUNCH_GLOBAL_EN_O,
  output logic                       PATCH_LOAD_O,
  output flpt_pkg::flpt_word_type    PATCH_ADDR_O
);
  import flpt_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < 7)
  begin : g_addr_check
    $error("ADDR_W too narrow for the register addresses");
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic flpt_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [31:0]       target);
    logic [ADDR_W-1:0] t;
    t = ADDR_W'(target);
    return (addr == t);
  endfunction

  flpt_if        sub ();

  logic          pg_meta_q;
  logic          pg_sync_q;
  logic          hit_feat;
  logic          hit_trig;
  logic          wr_any;
  logic          fault_d;
  flpt_word_type rdata_d;
  logic          rsp_valid_q;
  flpt_rsp_type  rsp_kind_q;
  flpt_word_type rsp_rdata_q;
  logic [31:0]   rsp_err_q;

  // ----------------------------------------------------------------------
  // power good synchroniser
  // ----------------------------------------------------------------------
  // no reset on these: a warm reset must still see the live pin level
  always_ff @(posedge CLK_I)
  begin
    pg_meta_q <= POWER_GOOD_I;
  end

  always_ff @(posedge CLK_I)
  begin
    pg_sync_q <= pg_meta_q;
  end

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  assign hit_feat = flpt_hit(REQ_ADDR_I, `FLPT_FEAT_ADDR);
  assign hit_trig = flpt_hit(REQ_ADDR_I, `FLPT_TRIG_ADDR);
  assign wr_any   = REQ_VALID_I & REQ_WRITE_I;

  assign sub.rst_n      = RST_N_I;
  assign sub.pg_ok      = pg_sync_q;
  assign sub.feat_virt  = FEAT_VIRT_I;
  assign sub.feat_safer = FEAT_SAFER_I;
  assign sub.wr_data    = REQ_WDATA_I;
  assign sub.wr_feat    = wr_any & hit_feat
                        & ~sub.feat_q[`FLPT_BIT_LOCK];
  assign sub.wr_trig    = wr_any & hit_trig & ~GUEST_XFER_I;

  // reads of the trigger and unmapped addresses fault like a bad write
  always_comb
  begin
    fault_d = 1'b0;
    rdata_d = '0;
    if (hit_feat)
    begin
      if (REQ_WRITE_I)
      begin
        fault_d = sub.feat_q[`FLPT_BIT_LOCK];
      end
      else
      begin
        rdata_d = sub.feat_q & `FLPT_IMPL_MASK;
      end
    end
    else if (hit_trig)
    begin
      fault_d = !REQ_WRITE_I || GUEST_XFER_I;
    end
    else
    begin
      fault_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= REQ_VALID_I;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      rsp_kind_q  <= FLPT_RSP_OK;
      rsp_rdata_q <= '0;
      rsp_err_q   <= `FLPT_GP_ERR_CODE;
    end
    else if (REQ_VALID_I)
    begin
      rsp_kind_q  <= fault_d ? FLPT_RSP_GP : FLPT_RSP_OK;
      rsp_rdata_q <= fault_d ? '0 : rdata_d;
      rsp_err_q   <= `FLPT_GP_ERR_CODE;
    end
  end

  // ----------------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------------
  flpt_lock_reg u_lock
  (
    .clk_i (CLK_I),
    .bus   (sub.lockreg)
  );

  flpt_patch_trig u_trig
  (
    .clk_i (CLK_I),
    .bus   (sub.trig)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign RSP_VALID_O        = rsp_valid_q;
  assign RSP_KIND_O         = rsp_kind_q;
  assign RSP_RDATA_O        = rsp_rdata_q;
  assign RSP_ERR_CODE_O     = rsp_err_q;
  assign LOCKED_O           = sub.feat_q[`FLPT_BIT_LOCK];
  assign VIRT_SAFER_EN_O    = sub.feat_q[`FLPT_BIT_VIRT_SAFER];
  assign VIRT_PLAIN_EN_O    = sub.feat_q[`FLPT_BIT_VIRT_PLAIN];
  assign LAUNCH_LOCAL_EN_O  = sub.local_avail;
  assign LAUNCH_GLOBAL_EN_O = sub.feat_q[`FLPT_BIT_GLOBAL];
  assign PATCH_LOAD_O       = sub.patch_load;
  assign PATCH_ADDR_O       = sub.patch_data;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (!RST_N_I);

  sequence s_feat_wr;
    REQ_VALID_I && REQ_WRITE_I && hit_feat;
  endsequence

  sequence s_open_wr;
    s_feat_wr and !sub.feat_q[`FLPT_BIT_LOCK];
  endsequence

  sequence s_trig_wr;
    REQ_VALID_I && REQ_WRITE_I && hit_trig;
  endsequence

  sequence s_feat_rd;
    REQ_VALID_I && !REQ_WRITE_I && hit_feat;
  endsequence

  a_locked_write_hold : assert property (
    s_feat_wr and sub.feat_q[`FLPT_BIT_LOCK] |=> $stable(sub.feat_q))
    else $error("locked feature register changed on a write");

  a_locked_gp_fault : assert property (
    s_feat_wr and sub.feat_q[`FLPT_BIT_LOCK]
    |=> RSP_VALID_O && RSP_KIND_O == FLPT_RSP_GP && RSP_ERR_CODE_O == 0)
    else $error("locked write did not raise a zero-code fault");

  a_warm_reset_keep : assert property (
    disable iff (1'b0)
    !RST_N_I && pg_sync_q && sub.feat_q[`FLPT_BIT_LOCK]
    |=> $stable(sub.feat_q))
    else $error("locked contents lost over a warm reset");

  a_cold_reset_clear : assert property (
    disable iff (1'b0)
    !RST_N_I && !pg_sync_q |=> sub.feat_q == 64'h0)
    else $error("power-good reset did not clear the register");

  a_safer_virt_set : assert property (
    s_open_wr and REQ_WDATA_I[1] && FEAT_VIRT_I && FEAT_SAFER_I
    |=> VIRT_SAFER_EN_O)
    else $error("virtualization with safer mode not enabled");

  a_plain_virt_gate : assert property (
    s_open_wr and !FEAT_VIRT_I |=> !VIRT_PLAIN_EN_O && !VIRT_SAFER_EN_O)
    else $error("virtualization enabled without the feature");

  a_launch_field_gate : assert property (
    s_open_wr and !FEAT_SAFER_I
    |=> sub.feat_q[`FLPT_BIT_GLOBAL:`FLPT_LOCAL_LO] == 8'h00)
    else $error("launch field written without safer mode");

  a_launch_global : assert property (
    LAUNCH_LOCAL_EN_O != 7'h00 |-> LAUNCH_GLOBAL_EN_O)
    else $error("local launch function open without global enable");

  a_reserved_zero : assert property (
    (sub.feat_q & ~`FLPT_IMPL_MASK) == 64'h0
    && (RSP_RDATA_O & ~`FLPT_IMPL_MASK) == 64'h0)
    else $error("reserved feature bits not zero");

  a_patch_pulse : assert property (
    s_trig_wr and !GUEST_XFER_I
    |=> PATCH_LOAD_O && PATCH_ADDR_O == $past(REQ_WDATA_I)
        && RSP_KIND_O == FLPT_RSP_OK)
    else $error("trigger write did not start a patch load");

  a_guest_block : assert property (
    s_trig_wr and GUEST_XFER_I
    |=> !PATCH_LOAD_O && RSP_KIND_O == FLPT_RSP_GP)
    else $error("trigger write not blocked during guest transfer");

  a_load_only_write : assert property (
    PATCH_LOAD_O |-> $past(wr_any && hit_trig))
    else $error("patch load without a trigger write");

  // the lock only falls through a power-good reset, never while running
  a_lock_sticky : assert property (
    LOCKED_O |=> LOCKED_O)
    else $error("lock bit cleared without a reset");

  // reserved bits are zero in storage, so a read shows the whole word
  a_feat_read_back : assert property (
    s_feat_rd |=> RSP_VALID_O && RSP_KIND_O == FLPT_RSP_OK
                  && RSP_RDATA_O == $past(sub.feat_q))
    else $error("feature register read returned wrong data");

  a_trig_read_fault : assert property (
    REQ_VALID_I && !REQ_WRITE_I && hit_trig
    |=> RSP_KIND_O == FLPT_RSP_GP && RSP_RDATA_O == 64'h0)
    else $error("read of the write-only trigger did not fault");

  a_fault_zero_code : assert property (
    RSP_VALID_O && RSP_KIND_O == FLPT_RSP_GP |-> RSP_ERR_CODE_O == 32'h0)
    else $error("fault answered with a nonzero error code");

  // unmapped places answer with a fault and never leak stored bits
  a_unmapped_fault : assert property (
    REQ_VALID_I && !hit_feat && !hit_trig
    |=> RSP_KIND_O == FLPT_RSP_GP && RSP_RDATA_O == 64'h0)
    else $error("unmapped access did not fault");

  // every request is answered next cycle, so no fault can go unseen
  a_answer_pulse : assert property (
    REQ_VALID_I |=> RSP_VALID_O)
    else $error("request left without an answer");

endmodule

// ===== core/flpt_consts.svh
`ifndef FLPT_CONSTS_SVH
`define FLPT_CONSTS_SVH

// ----------------------------------------------------------------------
// model register addresses
// ----------------------------------------------------------------------
`define FLPT_FEAT_ADDR      32'h0000003a
`define FLPT_TRIG_ADDR      32'h00000079

// ----------------------------------------------------------------------
// feature_lock_control field positions
// ----------------------------------------------------------------------
`define FLPT_BIT_LOCK       0
`define FLPT_BIT_VIRT_SAFER 1
`define FLPT_BIT_VIRT_PLAIN 2
`define FLPT_LOCAL_LO       8
`define FLPT_LOCAL_HI       14
`define FLPT_BIT_GLOBAL     15

// ----------------------------------------------------------------------
// reset values and answers
// ----------------------------------------------------------------------
`define FLPT_FEAT_RESET     64'h0000000000000000
`define FLPT_IMPL_MASK      64'h000000000000ff07
`define FLPT_GP_ERR_CODE    32'h00000000

`endif

// ===== core/flpt_pkg.sv
package flpt_pkg;

  typedef logic [63:0] flpt_word_type;
  typedef logic [6:0]  flpt_local_type;

  // answer kinds of a model register access
  typedef enum logic [1:0]
  {
    FLPT_RSP_OK = 2'b00,
    FLPT_RSP_GP = 2'b01
  } flpt_rsp_type;

endpackage

// ===== core/flpt_if.sv
`timescale 1ns/1ps

interface flpt_if;
  import flpt_pkg::*;

  logic           rst_n;
  logic           pg_ok;
  logic           feat_virt;
  logic           feat_safer;
  logic           wr_feat;
  logic           wr_trig;
  flpt_word_type  wr_data;
  flpt_word_type  feat_q;
  flpt_local_type local_avail;
  logic           patch_load;
  flpt_word_type  patch_data;

  modport core
  (
    output rst_n,
    output pg_ok,
    output feat_virt,
    output feat_safer,
    output wr_feat,
    output wr_trig,
    output wr_data,
    input  feat_q,
    input  local_avail,
    input  patch_load,
    input  patch_data
  );

  modport lockreg
  (
    input  rst_n,
    input  pg_ok,
    input  feat_virt,
    input  feat_safer,
    input  wr_feat,
    input  wr_data,
    output feat_q,
    output local_avail
  );

  modport trig
  (
    input  rst_n,
    input  wr_trig,
    input  wr_data,
    output patch_load,
    output patch_data
  );

endinterface

// ===== core/flpt_lock_reg.sv
`timescale 1ns/1ps
`include "flpt_consts.svh"

module flpt_lock_reg
(
  input  wire logic clk_i,
  flpt_if.lockreg   bus
);
  import flpt_pkg::*;

  flpt_word_type wr_mask;
  flpt_word_type feat_d;

  // ----------------------------------------------------------------------
  // write mask from the reported features
  // ----------------------------------------------------------------------
  always_comb
  begin
    wr_mask = '0;
    wr_mask[`FLPT_BIT_LOCK] = bus.feat_virt | bus.feat_safer;
    wr_mask[`FLPT_BIT_VIRT_SAFER] = bus.feat_virt & bus.feat_safer;
    wr_mask[`FLPT_BIT_VIRT_PLAIN] = bus.feat_virt;
    wr_mask[`FLPT_BIT_GLOBAL] = bus.feat_safer;
    for (int i = `FLPT_LOCAL_LO; i <= `FLPT_LOCAL_HI; i++)
    begin
      wr_mask[i] = bus.feat_safer;
    end
  end

  always_comb
  begin
    feat_d = bus.feat_q;
    if (!bus.rst_n)
    begin
      // a warm reset keeps the contents; only a power loss clears them
      if (!bus.pg_ok)
      begin
        feat_d = `FLPT_FEAT_RESET;
      end
    end
    else if (bus.wr_feat && !bus.feat_q[`FLPT_BIT_LOCK])
    begin
      feat_d = bus.wr_data & wr_mask;
    end
  end

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    bus.feat_q <= feat_d;
  end

  // local functions stay unavailable while the global enable is clear
  always_ff @(posedge clk_i)
  begin
    bus.local_avail <= feat_d[`FLPT_LOCAL_HI:`FLPT_LOCAL_LO]
                     & {7{feat_d[`FLPT_BIT_GLOBAL]}};
  end

endmodule

// ===== core/flpt_patch_trig.sv
`timescale 1ns/1ps
`include "flpt_consts.svh"

module flpt_patch_trig
(
  input  wire logic clk_i,
  flpt_if.trig      bus
);
  import flpt_pkg::*;

  // ----------------------------------------------------------------------
  // one-cycle load request with the written word
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!bus.rst_n)
    begin
      bus.patch_load <= 1'b0;
    end
    else
    begin
      bus.patch_load <= bus.wr_trig;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!bus.rst_n)
    begin
      bus.patch_data <= '0;
    end
    else if (bus.wr_trig)
    begin
      bus.patch_data <= bus.wr_data;
    end
  end

endmodule

// ===== bench/flpt_testbench.sv
`timescale 1ns/1ps
`include "flpt_consts.svh"

module testbench;
  import flpt_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic            clk;
  logic            rst_n;
  logic            pwr_good;
  logic            has_virt;
  logic            has_safer;
  logic            guest_xfer;
  logic            req_valid;
  logic            req_write;
  logic [31:0]     req_addr;
  flpt_word_type   req_wdata;
  logic            rsp_valid;
  flpt_rsp_type    rsp_kind;
  flpt_word_type   rsp_rdata;
  logic [31:0]     rsp_err;
  logic            locked;
  logic            virt_safer;
  logic            virt_plain;
  flpt_local_type  local_en;
  logic            global_en;
  logic            patch_load;
  flpt_word_type   patch_addr;
  int              errors;
  int              tests_run;
  int              cycles;

  flpt_top #(.ADDR_W(32)) uut
  (
    .CLK_I              (clk),
    .RST_N_I            (rst_n),
    .POWER_GOOD_I       (pwr_good),
    .FEAT_VIRT_I        (has_virt),
    .FEAT_SAFER_I       (has_safer),
    .GUEST_XFER_I       (guest_xfer),
    .REQ_VALID_I        (req_valid),
    .REQ_WRITE_I        (req_write),
    .REQ_ADDR_I         (req_addr),
    .REQ_WDATA_I        (req_wdata),
    .RSP_VALID_O        (rsp_valid),
    .RSP_KIND_O         (rsp_kind),
    .RSP_RDATA_O        (rsp_rdata),
    .RSP_ERR_CODE_O     (rsp_err),
    .LOCKED_O           (locked),
    .VIRT_SAFER_EN_O    (virt_safer),
    .VIRT_PLAIN_EN_O    (virt_plain),
    .LAUNCH_LOCAL_EN_O  (local_en),
    .LAUNCH_GLOBAL_EN_O (global_en),
    .PATCH_LOAD_O       (patch_load),
    .PATCH_ADDR_O       (patch_addr)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang in the access loop would otherwise run forever
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // access protocol
  // ----------------------------------------------------------------------
  // one request, answer sampled in the cycle after the taking edge
  task automatic acc(input logic wr, input logic [31:0] addr,
                     input flpt_word_type data, input flpt_rsp_type kind,
                     input flpt_word_type rd, input logic load);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= addr;
    req_wdata <= data;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    check("rsp_valid", rsp_valid, 1'b1);
    check("rsp_kind", rsp_kind, kind);
    check("rsp_rdata", rsp_rdata, rd);
    check("rsp_err", rsp_err, `FLPT_GP_ERR_CODE);
    check("patch_load", patch_load, load);
  endtask

  // power good settles through the synchroniser before reset is applied
  task automatic do_reset(input logic pg);
    @(posedge clk);
    pwr_good <= pg;
    repeat (4) @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n    <= 1'b1;
    pwr_good <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    errors     = 0;
    tests_run  = 0;
    cycles     = 0;
    rst_n      = 1'b0;
    pwr_good   = 1'b0;
    has_virt   = 1'b0;
    has_safer  = 1'b0;
    guest_xfer = 1'b0;
    req_valid  = 1'b0;
    req_write  = 1'b0;
    req_addr   = 32'h00000000;
    req_wdata  = 64'h0000000000000000;
    repeat (4) @(posedge clk);
    rst_n    <= 1'b1;
    pwr_good <= 1'b1;
    repeat (4) @(posedge clk);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, `FLPT_FEAT_RESET, 0);
    // no features reported: every field masked, no fault
    acc(1, `FLPT_FEAT_ADDR, 64'hff00, FLPT_RSP_OK, 0, 0);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 0, 0);
    @(posedge clk);
    has_virt <= 1'b1;
    acc(1, `FLPT_FEAT_ADDR, 64'h4, FLPT_RSP_OK, 0, 0);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 64'h4, 0);
    check("virt_plain", virt_plain, 1'b1);
    check("virt_safer", virt_safer, 1'b0);
    @(posedge clk);
    has_safer <= 1'b1;
    acc(1, `FLPT_FEAT_ADDR, 64'hffffffffffff7f06, FLPT_RSP_OK, 0, 0);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 64'h7f06, 0);
    check("local_en", local_en, 7'h00);
    check("global_en", global_en, 1'b0);
    acc(1, `FLPT_FEAT_ADDR, 64'hff07, FLPT_RSP_OK, 0, 0);
    check("locked", locked, 1'b1);
    check("virt_safer", virt_safer, 1'b1);
    check("local_en", local_en, 7'h7f);
    check("global_en", global_en, 1'b1);
    // locked: write refused with a fault, contents unchanged
    acc(1, `FLPT_FEAT_ADDR, 0, FLPT_RSP_GP, 0, 0);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 64'hff07, 0);
    do_reset(1'b1);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 64'hff07, 0);
    check("locked", locked, 1'b1);
    do_reset(1'b0);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 0, 0);
    check("locked", locked, 1'b0);
    acc(1, `FLPT_FEAT_ADDR, 64'h6, FLPT_RSP_OK, 0, 0);
    acc(0, `FLPT_FEAT_ADDR, 0, FLPT_RSP_OK, 64'h6, 0);
    // two patch triggers, then a blocked one during guest transfer
    acc(1, `FLPT_TRIG_ADDR, 64'h0123456789abcdef, FLPT_RSP_OK, 0, 1);
    check("patch_addr", patch_addr, 64'h0123456789abcdef);
    acc(1, `FLPT_TRIG_ADDR, 64'h55, FLPT_RSP_OK, 0, 1);
    check("patch_addr", patch_addr, 64'h55);
    @(posedge clk);
    guest_xfer <= 1'b1;
    acc(1, `FLPT_TRIG_ADDR, 64'haa, FLPT_RSP_GP, 0, 0);
    check("patch_addr", patch_addr, 64'h55);
    @(posedge clk);
    guest_xfer <= 1'b0;
    // write-only trigger and an unmapped place both fault
    acc(0, `FLPT_TRIG_ADDR, 0, FLPT_RSP_GP, 0, 0);
    acc(0, 32'h00000010, 0, FLPT_RSP_GP, 0, 0);
    acc(1, 32'h00000010, 64'h1, FLPT_RSP_GP, 0, 0);
    check("virt_plain", virt_plain, 1'b1);
    repeat (2) @(posedge clk);
    test_done();
  end

endmodule
